/* logic/gplc_pkg.sv */
// constants and types for the low-pin port configuration register
package gplc_pkg;

  // register group placement on the peripheral bus
  localparam logic [31:0] GPLC_PORT_A_BASE   = 32'h4001_0800;
  localparam logic [31:0] GPLC_PORT_B_BASE   = 32'h4001_0C00;
  localparam logic [31:0] GPLC_PORT_STEP     = 32'h0000_0400;
  localparam logic [31:0] GPLC_ALT_FUNC_BASE = 32'h4001_0000;
  localparam int          GPLC_PORT_COUNT    = 5;

  // register offset within a port group and its reset value
  localparam logic [31:0] GPLC_LOW_CFG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] GPLC_LOW_CFG_RESET  = 32'h4444_4444;

  // field layout: one nibble per pin
  localparam int GPLC_PIN_COUNT  = 8;
  localparam int GPLC_NIBBLE     = 4;
  localparam int GPLC_MODE_LSB   = 0;
  localparam int GPLC_CFG_LSB    = 2;
  localparam int GPLC_FIELD_BITS = 2;

  // direction and speed field codes
  typedef enum logic [1:0] {
    GPLC_MODE_INPUT  = 2'h0,
    GPLC_MODE_OUT10M = 2'h1,
    GPLC_MODE_OUT2M  = 2'h2,
    GPLC_MODE_OUT50M = 2'h3
  } gplc_mode_e;

  // driver type codes while the pin is an input
  typedef enum logic [1:0] {
    GPLC_IN_ANALOG = 2'h0,
    GPLC_IN_FLOAT  = 2'h1,
    GPLC_IN_PULL   = 2'h2,
    GPLC_IN_RSVD   = 2'h3
  } gplc_in_kind_e;

  // driver type codes while the pin is an output
  typedef enum logic [1:0] {
    GPLC_OUT_GP_PP = 2'h0,
    GPLC_OUT_GP_OD = 2'h1,
    GPLC_OUT_AF_OD = 2'h2,
    GPLC_OUT_AF_PP = 2'h3
  } gplc_out_kind_e;

  // decoded control for one pin driver
  typedef struct packed {
    gplc_mode_e     mode;
    logic           is_output;
    gplc_in_kind_e  in_kind;
    gplc_out_kind_e out_kind;
    logic           alt_func;
    logic           open_drain;
    logic           pull_en;
    logic           analog_en;
    logic           rsvd_code;
  } gplc_pin_ctl_s;

endpackage

/* logic/gplc_low_cfg.sv */
// low-pin port configuration register with APB slave and pin decode
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps

// Operation
// - Port groups start at 0x40010800 for port A and 0x40010C00 for port B, stepping 0x400 for C to E, with the alternate-function block at 0x40010000.
// - The pin 0 to 7 configuration register is a 32-bit register at offset 0x00 of the port group.
// - Reset loads 0x44444444, leaving every pin a floating input.
// - Pin n owns a nibble: bits 4n+1:4n are its mode and bits 4n+3:4n+2 its configuration.
// - All fields are software read/write and no hardware event alters them after reset.
// - Mode 00 is input, 01 output at 10MHz, 10 output at 2MHz, 11 output at 50MHz.
// - The configuration field uses the input coding for mode 00 and the output coding otherwise.
// - Input coding is 00 analog, 01 floating, 10 pull-up or pull-down, 11 reserved.
// - Output coding is 00 push-pull, 01 open-drain, 10 alternate-function open-drain.
module gplc_low_cfg #(
  parameter int PORT_INDEX = 0
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [31:0]           paddr_in,
  input  wire logic [31:0]           pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic      [31:0]           port_low_pin_config_out,
  output gplc_pkg::gplc_pin_ctl_s [7:0] pin_ctl_out
);
  import gplc_pkg::*;

  // group base of this port instance
  localparam logic [31:0] GROUP_BASE =
    GPLC_PORT_A_BASE + GPLC_PORT_STEP * 32'(PORT_INDEX);
  localparam logic [31:0] CFG_ADDR = GROUP_BASE + GPLC_LOW_CFG_OFFSET;

  logic [31:0]                  cfg_q;
  logic [31:0]                  cfg_d;
  logic                         hit;
  logic                         setup;
  logic                         wr_acc;
  gplc_pin_ctl_s [7:0]          ctl_d;
  logic [1:0]                   pin0_direction_speed;
  logic [1:0]                   pin1_direction_speed;
  logic [1:0]                   pin2_direction_speed;
  logic [1:0]                   pin3_direction_speed;
  logic [1:0]                   pin4_direction_speed;
  logic [1:0]                   pin5_direction_speed;
  logic [1:0]                   pin6_direction_speed;
  logic [1:0]                   pin7_direction_speed;
  logic [1:0]                   pin0_driver_type;
  logic [1:0]                   pin1_driver_type;
  logic [1:0]                   pin2_driver_type;
  logic [1:0]                   pin3_driver_type;
  logic [1:0]                   pin4_driver_type;
  logic [1:0]                   pin5_driver_type;
  logic [1:0]                   pin6_driver_type;
  logic [1:0]                   pin7_driver_type;

  // merge write data into the word under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // turn one pin nibble into driver controls
  function automatic gplc_pin_ctl_s pin_decode(input logic [3:0] nib);
    gplc_pin_ctl_s c;
    logic [1:0]    md;
    logic [1:0]    cf;
    md = nib[GPLC_MODE_LSB +: GPLC_FIELD_BITS];
    cf = nib[GPLC_CFG_LSB +: GPLC_FIELD_BITS];
    c = '0;
    c.mode      = gplc_mode_e'(md);
    c.is_output = (md != 2'h0);
    c.in_kind   = GPLC_IN_FLOAT;
    c.out_kind  = GPLC_OUT_GP_PP;
    if (!c.is_output) begin
      c.in_kind = gplc_in_kind_e'(cf);
      case (cf)
        2'h0: c.analog_en = 1'b1;
        2'h1: c.analog_en = 1'b0;
        2'h2: c.pull_en   = 1'b1;
        2'h3: c.rsvd_code = 1'b1;
        default: c.rsvd_code = 1'b1;
      endcase
    end else begin
      c.out_kind = gplc_out_kind_e'(cf);
      case (cf)
        2'h0: c.open_drain = 1'b0;
        2'h1: c.open_drain = 1'b1;
        2'h2: begin
          c.alt_func   = 1'b1;
          c.open_drain = 1'b1;
        end
        2'h3: c.alt_func = 1'b1;
        default: c.alt_func = 1'b0;
      endcase
    end
    return c;
  endfunction

  // bus phase decode; only the exact word address is mapped
  assign hit    = (paddr_in == CFG_ADDR);
  assign setup  = psel_in && !penable_in;
  assign wr_acc = psel_in && penable_in && pwrite_in && hit;

  // zero-wait slave: access phase always completes
  assign pready_out = psel_in && penable_in;

  // next register value; only a bus write changes it
  always_comb begin
    cfg_d = cfg_q;
    if (wr_acc) begin
      cfg_d = strb_merge(cfg_q, pwdata_in, pstrb_in);
    end
  end

  // configuration word
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cfg_q <= GPLC_LOW_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // direction and speed field of each pin in the next value
  assign pin0_direction_speed = cfg_d[0*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin1_direction_speed = cfg_d[1*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin2_direction_speed = cfg_d[2*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin3_direction_speed = cfg_d[3*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin4_direction_speed = cfg_d[4*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin5_direction_speed = cfg_d[5*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin6_direction_speed = cfg_d[6*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];
  assign pin7_direction_speed = cfg_d[7*GPLC_NIBBLE+GPLC_MODE_LSB +: GPLC_FIELD_BITS];

  // driver type field of each pin in the next value
  assign pin0_driver_type = cfg_d[0*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin1_driver_type = cfg_d[1*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin2_driver_type = cfg_d[2*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin3_driver_type = cfg_d[3*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin4_driver_type = cfg_d[4*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin5_driver_type = cfg_d[5*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin6_driver_type = cfg_d[6*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];
  assign pin7_driver_type = cfg_d[7*GPLC_NIBBLE+GPLC_CFG_LSB +: GPLC_FIELD_BITS];

  // per-pin decode of the next value
  always_comb begin
    ctl_d[0] = pin_decode({pin0_driver_type, pin0_direction_speed});
    ctl_d[1] = pin_decode({pin1_driver_type, pin1_direction_speed});
    ctl_d[2] = pin_decode({pin2_driver_type, pin2_direction_speed});
    ctl_d[3] = pin_decode({pin3_driver_type, pin3_direction_speed});
    ctl_d[4] = pin_decode({pin4_driver_type, pin4_direction_speed});
    ctl_d[5] = pin_decode({pin5_driver_type, pin5_direction_speed});
    ctl_d[6] = pin_decode({pin6_driver_type, pin6_direction_speed});
    ctl_d[7] = pin_decode({pin7_driver_type, pin7_direction_speed});
  end

  // registered pin controls, same edge as the register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int p = 0; p < GPLC_PIN_COUNT; p++) begin
        pin_ctl_out[p] <= pin_decode(GPLC_LOW_CFG_RESET[GPLC_NIBBLE*p +: GPLC_NIBBLE]);
      end
      port_low_pin_config_out <= GPLC_LOW_CFG_RESET;
    end else begin
      pin_ctl_out             <= ctl_d;
      port_low_pin_config_out <= cfg_d;
    end
  end

  // read data and error captured in the setup phase
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out  <= (hit && !pwrite_in) ? cfg_q : 32'h0000_0000;
      pslverr_out <= !hit;
    end
  end

endmodule // gplc_low_cfg

/* verification/gplc_low_cfg_assertions.sv */
// concurrent checks on the low-pin configuration register ports
`timescale 1ns/100ps
module gplc_low_cfg_assertions #(
  parameter int PORT_INDEX = 0
) (
  input wire logic                         core_clk_in,
  input wire logic                         srst_in,
  input wire logic                         psel_in,
  input wire logic                         penable_in,
  input wire logic                         pwrite_in,
  input wire logic [31:0]                  paddr_in,
  input wire logic [31:0]                  pwdata_in,
  input wire logic [3:0]                   pstrb_in,
  input wire logic [31:0]                  prdata_out,
  input wire logic                         pready_out,
  input wire logic                         pslverr_out,
  input wire logic [31:0]                  port_low_pin_config_out,
  input gplc_pkg::gplc_pin_ctl_s [7:0]     pin_ctl_out
);
  import gplc_pkg::*;
  localparam logic [31:0] BASE = GPLC_PORT_A_BASE + GPLC_PORT_STEP * 32'(PORT_INDEX);
  wire logic hit = paddr_in == BASE;
  wire logic [31:0] cfg = port_low_pin_config_out;
  // all checks on the bus clock, quiet in reset
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  reset_value_a: assert property ($past(srst_in) |-> cfg == 32'h4444_4444)
    else $error("register not at reset value");
  ready_zero_a: assert property (psel_in && penable_in |-> pready_out)
    else $error("no ready in access cycle");
  unmapped_err_a: assert property (psel_in && !penable_in && !hit |=> pslverr_out)
    else $error("unmapped access not refused");
  read_data_a: assert property (psel_in && !penable_in && !pwrite_in && hit |=>
    prdata_out == $past(cfg)) else $error("read data wrong");
  write_full_a: assert property (psel_in && penable_in && pwrite_in && hit &&
    pstrb_in == 4'hF |=> cfg == $past(pwdata_in)) else $error("write not taken");
  hold_value_a: assert property (!(psel_in && penable_in && pwrite_in) |=> $stable(cfg))
    else $error("register changed without write");
  mode_field_a: assert property (pin_ctl_out[7].mode == cfg[29:28])
    else $error("pin mode decode wrong");
  pin_direction_a: assert property (pin_ctl_out[7].is_output == (cfg[29:28] != 2'h0))
    else $error("pin direction decode wrong");
  alt_pp_a: assert property (pin_ctl_out[7].is_output && cfg[31:30] == 2'h3 |->
    pin_ctl_out[7].alt_func && !pin_ctl_out[7].open_drain) else $error("af push-pull wrong");
endmodule // gplc_low_cfg_assertions
bind gplc_low_cfg gplc_low_cfg_assertions #(.PORT_INDEX(PORT_INDEX)) chk_u (.*);

/* verification/tb_gpio_low_pin_config_register.sv */
// self-checking bench for the low-pin configuration register
`timescale 1ns/100ps
module tb_gpio_low_pin_config_register;
  import gplc_pkg::*;
  localparam logic [31:0] BASE = GPLC_PORT_B_BASE;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, cfg, rd, v;
  logic [3:0] pstrb = 0, c;
  logic rdy, err, er;
  gplc_pin_ctl_s [7:0] pc;
  int fail_count = 0, compares = 0, n;
  gplc_low_cfg #(.PORT_INDEX(1)) dut_u (.core_clk_in(clk), .srst_in(srst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(rdy), .pslverr_out(err),
    .port_low_pin_config_out(cfg), .pin_ctl_out(pc));
  // 100 ns bus clock
  initial forever #50 clk = ~clk;
  task chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do @(posedge clk); while (rdy !== 1'b1 && ++n < 50);
    if (rdy !== 1'b1) begin
      fail_count++;
      $display("MISMATCH pready exp 1 got %b", rdy);
    end
    rd = prdata; er = err;
    psel <= 0; pen <= 0;
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
  // test sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    xfer(0, BASE, 0, 0); chk("reset", 32'h4444_4444, rd);
    chk("reset cfg", GPLC_LOW_CFG_RESET, cfg);
    chk("reset dir", 0, pc[7].is_output);
    chk("reset kind", GPLC_IN_FLOAT, pc[7].in_kind);
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      v = {8{c}};
      xfer(1, BASE, v, 4'hF); chk("cfg", v, cfg);
      xfer(0, BASE, 0, 0); chk("rd", v, rd);
      chk("mode", c[1:0], pc[3].mode);
      chk("dir", c[1:0] != 0, pc[3].is_output);
      chk("rd err", 0, er);
      if (c[1:0] != 0) chk("out kind", c[3:2], pc[3].out_kind);
      else chk("in kind", c[3:2], pc[3].in_kind);
      chk("analog", c[1:0] == 0 && c[3:2] == 0, pc[3].analog_en);
      chk("pull", c[1:0] == 0 && c[3:2] == 2, pc[3].pull_en);
      chk("rsvd", c[1:0] == 0 && c[3:2] == 3, pc[3].rsvd_code);
      chk("od", c[1:0] != 0 && (c[3:2] == 1 || c[3:2] == 2), pc[3].open_drain);
      chk("af", c[1:0] != 0 && c[3], pc[3].alt_func);
    end
    xfer(1, BASE, 32'h0, 4'h1); chk("strb", 32'hFFFF_FF00, cfg);
    xfer(1, GPLC_PORT_A_BASE, 0, 4'hF); chk("unmapped wr", 32'hFFFF_FF00, cfg);
    chk("unmapped wr err", 1, er);
    xfer(0, BASE + 4, 0, 0); chk("err", 1, er);
    chk("err data", 0, rd);
    report_and_stop;
  end
endmodule // tb_gpio_low_pin_config_register
